/* logic/alu_exec.sv */
`default_nettype none

// Functional notes
// - OR and set-bits ops OR constant into Rd, set Z N V, one cycle.
// - clear_bits_masked ANDs Rd with inverted constant, Z N V, one cycle.
// - test_reg ANDs register with itself, Z N V from result, one cycle.
// - Integer products write 16 bits to pair 1:0, only Z C, two cycles.
// - Fractional products shift product left once, Z C, two cycles.
// - pointer_jump loads PC from Z pointer, no flags, two cycles.
// - Subroutine entry saves return address, PC from Z, three cycles.
// - equal_compare_skip skips next instruction when equal, 1/2/3 cycles.
// - immediate_compare subtracts constant unstored, Z N V C H, one cycle.
// - Register bit skips skip on bit clear or set, 1/2/3 cycles.
// - Port bit skips skip on I/O bit clear or set, 1/2/3 cycles.
// - Status bit branches add offset plus one when bit matches; 1/2.
// - Carry branches take branch when carry is set or clear.
// - Unsigned branches: carry clear same-or-higher, set lower; 1/2.
// - branch_signed_ge branches when N xor V is zero.
// - branch_signed_lt branches when N xor V is one.
// - Half-carry branches on H set or clear, one or two cycles.
// - Transfer bit branches on T set or clear.
// - Overflow branches on V set or clear, flags unchanged.
module alu_exec
    import alu_exec_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Instruction issue
    input wire logic cmd_valid,
    input wire exec_req_t cmd_req,
    output logic cmd_ready,
    // Completion
    output logic done,
    output exec_rsp_t rsp
);

    // ****************************************************************
    // Decode helpers
    // ****************************************************************
    function automatic logic is_product(input exec_op_t op);
        return op inside {op_unsigned_product, op_signed_product,
            op_mixed_sign_product, op_fractional_unsigned_product,
            op_fractional_signed_product, op_fractional_mixed_product};
    endfunction

    function automatic logic is_skip(input exec_op_t op);
        return op inside {op_equal_compare_skip, op_skip_reg_bit_clear,
            op_skip_reg_bit_set, op_skip_port_bit_clear,
            op_skip_port_bit_set};
    endfunction

    function automatic logic is_branch(input exec_op_t op);
        return op >= op_branch_status_bit_set;
    endfunction

    typedef enum logic {st_idle, st_exec} exec_state_t;

    exec_state_t state_ff;
    logic [1:0] wait_ff;
    logic [7:0] status_ff;
    logic [15:0] pc_ff;
    logic done_ff;
    exec_rsp_t rsp_ff;
    logic [15:0] result_ff;
    logic [15:0] reg_rdata_ff;

    logic accept;
    logic take;
    logic [1:0] nxt_cycles;
    logic [7:0] nxt_status;
    logic [15:0] nxt_pc;
    exec_rsp_t nxt_rsp;
    logic [15:0] pc_rel;
    logic [7:0] logic_res;
    logic [8:0] mul_a;
    logic [8:0] mul_b;
    logic [17:0] mul_full;
    logic [15:0] product;
    logic [15:0] product_out;
    logic [7:0] cmp_res;
    logic [7:0] st;

    // A new instruction may issue in the last cycle of the previous one
    assign cmd_ready = (state_ff == st_idle) || (wait_ff == 2'h0);
    assign accept = cmd_valid && cmd_ready;
    assign done = done_ff;
    assign rsp = rsp_ff;
    assign reg_rdata = reg_rdata_ff;
    assign st = status_ff;

    // ****************************************************************
    // Datapath
    // ****************************************************************
    assign pc_rel = pc_ff + {{9{cmd_req.offset[6]}}, cmd_req.offset}
        + 16'h0001;
    assign cmp_res = cmd_req.rd_val - cmd_req.imm;

    always_comb begin
        mul_a = {1'b0, cmd_req.rd_val};
        mul_b = {1'b0, cmd_req.rr_val};
        if (cmd_req.op inside {op_signed_product, op_mixed_sign_product,
                op_fractional_signed_product,
                op_fractional_mixed_product}) begin
            mul_a = {cmd_req.rd_val[7], cmd_req.rd_val};
        end
        if (cmd_req.op inside {op_signed_product,
                op_fractional_signed_product}) begin
            mul_b = {cmd_req.rr_val[7], cmd_req.rr_val};
        end
    end

    // Full-width context so the 9-bit operands are not multiplied at 9 bits
    assign mul_full = $signed(mul_a) * $signed(mul_b);
    assign product = mul_full[15:0];

    always_comb begin
        product_out = product;
        if (cmd_req.op inside {op_fractional_unsigned_product,
                op_fractional_signed_product,
                op_fractional_mixed_product}) begin
            product_out = {product[14:0], 1'b0};
        end
    end

    always_comb begin
        case (cmd_req.op)
            op_clear_bits_masked: logic_res = cmd_req.rd_val & ~cmd_req.imm;
            op_test_reg: logic_res = cmd_req.rd_val & cmd_req.rd_val;
            default: logic_res = cmd_req.rd_val | cmd_req.imm;
        endcase
    end

    // ****************************************************************
    // Condition evaluation
    // ****************************************************************
    always_comb begin
        case (cmd_req.op)
            op_equal_compare_skip: take = cmd_req.rd_val == cmd_req.rr_val;
            op_skip_reg_bit_clear: take = !cmd_req.rr_val[cmd_req.bit_sel];
            op_skip_reg_bit_set: take = cmd_req.rr_val[cmd_req.bit_sel];
            op_skip_port_bit_clear: take = !cmd_req.io_bit;
            op_skip_port_bit_set: take = cmd_req.io_bit;
            op_branch_status_bit_set: take = st[cmd_req.bit_sel];
            op_branch_status_bit_clear: take = !st[cmd_req.bit_sel];
            op_branch_carry_set: take = st[FLAG_C];
            op_branch_carry_clear: take = !st[FLAG_C];
            op_branch_unsigned_ge: take = !st[FLAG_C];
            op_branch_unsigned_below: take = st[FLAG_C];
            op_branch_signed_ge: take = !(st[FLAG_N] ^ st[FLAG_V]);
            op_branch_signed_lt: take = st[FLAG_N] ^ st[FLAG_V];
            op_branch_half_carry_set: take = st[FLAG_H];
            op_branch_half_carry_clear: take = !st[FLAG_H];
            op_branch_transfer_bit_set: take = st[FLAG_T];
            op_branch_transfer_bit_clear: take = !st[FLAG_T];
            op_branch_overflow_set: take = st[FLAG_V];
            op_branch_overflow_clear: take = !st[FLAG_V];
            default: take = 1'b0;
        endcase
    end

    // ****************************************************************
    // Next flags, program counter, answer and cycle count
    // ****************************************************************
    always_comb begin
        nxt_status = status_ff;
        nxt_pc = pc_ff + 16'h0001;
        nxt_rsp = '0;
        nxt_cycles = CYC_ONE;
        case (cmd_req.op)
            op_or_immediate, op_set_bits_masked, op_clear_bits_masked,
            op_test_reg: begin
                nxt_status[FLAG_Z] = logic_res == 8'h00;
                nxt_status[FLAG_N] = logic_res[7];
                nxt_status[FLAG_V] = 1'b0;
                nxt_rsp.wr_dest = cmd_req.op != op_test_reg;
                nxt_rsp.dest_val = logic_res;
            end
            op_immediate_compare: begin
                nxt_status[FLAG_Z] = cmp_res == 8'h00;
                nxt_status[FLAG_N] = cmp_res[7];
                nxt_status[FLAG_V] =
                    (cmd_req.rd_val[7] & ~cmd_req.imm[7] & ~cmp_res[7])
                    | (~cmd_req.rd_val[7] & cmd_req.imm[7] & cmp_res[7]);
                nxt_status[FLAG_C] = (~cmd_req.rd_val[7] & cmd_req.imm[7])
                    | (cmd_req.imm[7] & cmp_res[7])
                    | (cmp_res[7] & ~cmd_req.rd_val[7]);
                nxt_status[FLAG_H] = (~cmd_req.rd_val[3] & cmd_req.imm[3])
                    | (cmd_req.imm[3] & cmp_res[3])
                    | (cmp_res[3] & ~cmd_req.rd_val[3]);
            end
            op_pointer_jump: begin
                nxt_pc = cmd_req.z_ptr;
                nxt_cycles = CYC_TWO;
            end
            op_pointer_subroutine_entry: begin
                nxt_pc = cmd_req.z_ptr;
                nxt_rsp.push_ret = 1'b1;
                nxt_rsp.ret_addr = pc_ff + 16'h0001;
                nxt_cycles = CYC_THREE;
            end
            default: begin
                if (is_product(cmd_req.op)) begin
                    // Carry is the product's top bit before the shift
                    nxt_status[FLAG_C] = product[15];
                    nxt_status[FLAG_Z] = product_out == 16'h0000;
                    nxt_rsp.wr_pair = 1'b1;
                    nxt_rsp.pair_val = product_out;
                    nxt_cycles = CYC_TWO;
                end else if (is_skip(cmd_req.op) && take) begin
                    nxt_pc = cmd_req.next_two_word ? pc_ff + 16'h0003
                        : pc_ff + 16'h0002;
                    nxt_cycles = cmd_req.next_two_word ? CYC_THREE
                        : CYC_TWO;
                end else if (is_branch(cmd_req.op) && take) begin
                    nxt_pc = pc_rel;
                    nxt_cycles = CYC_TWO;
                end
            end
        endcase
    end

    // ****************************************************************
    // Sequencing
    // ****************************************************************
    // Architectural state is committed at issue so a following branch
    // sees the new flags; the remaining cycles only hold off issue.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            state_ff <= st_idle;
            wait_ff <= 2'h0;
        end else if (accept) begin
            state_ff <= st_exec;
            wait_ff <= nxt_cycles - CYC_ONE;
        end else if (state_ff == st_exec) begin
            if (wait_ff == 2'h0) begin
                state_ff <= st_idle;
            end else begin
                wait_ff <= wait_ff - 2'h1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            done_ff <= 1'b0;
        end else begin
            done_ff <= state_ff == st_exec && wait_ff == 2'h1
                || accept && nxt_cycles == CYC_ONE;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            rsp_ff <= '0;
            result_ff <= 16'h0000;
        end else if (accept) begin
            rsp_ff <= nxt_rsp;
            if (nxt_rsp.wr_pair) begin
                result_ff <= nxt_rsp.pair_val;
            end else if (nxt_rsp.wr_dest) begin
                result_ff <= {8'h00, nxt_rsp.dest_val};
            end
        end
    end

    // Instruction commit wins over a software write in the same cycle
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            status_ff <= STATUS_RESET;
        end else if (accept) begin
            status_ff <= nxt_status;
        end else if (reg_wr && reg_addr == ADDR_STATUS) begin
            status_ff <= reg_wdata[7:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            pc_ff <= PC_RESET;
        end else if (accept) begin
            pc_ff <= nxt_pc;
        end else if (reg_wr && reg_addr == ADDR_PC) begin
            pc_ff <= reg_wdata;
        end
    end

    // ****************************************************************
    // Register read port
    // ****************************************************************
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            reg_rdata_ff <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                ADDR_STATUS: reg_rdata_ff <= {8'h00, status_ff};
                ADDR_PC: reg_rdata_ff <= pc_ff;
                ADDR_RESULT: reg_rdata_ff <= result_ff;
                ADDR_STATE: reg_rdata_ff <= {13'h0000, wait_ff,
                    state_ff == st_exec};
                default: reg_rdata_ff <= 16'h0000;
            endcase
        end else begin
            reg_rdata_ff <= 16'h0000;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    a_logic_flags: assert property (accept && cmd_req.op inside
        {op_or_immediate, op_set_bits_masked, op_clear_bits_masked,
        op_test_reg} |=> done && !status_ff[FLAG_V]
        && status_ff[FLAG_Z] == ($past(logic_res) == 8'h00)
        && status_ff[7:4] == $past(status_ff[7:4]))
        else $error("logic op flags or timing wrong");

    a_clear_bits_value: assert property (accept
        && cmd_req.op == op_clear_bits_masked |=> rsp.dest_val
        == ($past(cmd_req.rd_val) & ~$past(cmd_req.imm)))
        else $error("clear bits result wrong");

    a_test_no_write: assert property (accept && cmd_req.op == op_test_reg
        |=> !rsp.wr_dest && status_ff[FLAG_N] == $past(cmd_req.rd_val[7]))
        else $error("test op wrote or set N wrong");

    a_product_two_cyc: assert property (accept && is_product(cmd_req.op)
        |=> !done ##1 done)
        else $error("product not two cycles");

    a_product_flags: assert property (accept && is_product(cmd_req.op)
        |=> status_ff[7:2] == $past(status_ff[7:2])
        && status_ff[FLAG_C] == $past(product[15]))
        else $error("product changed wrong flags");

    a_frac_shift: assert property (accept
        && cmd_req.op == op_fractional_unsigned_product
        |=> rsp.pair_val == 16'({8'h00, $past(cmd_req.rd_val)}
        * {8'h00, $past(cmd_req.rr_val)} << 1))
        else $error("fractional product not shifted");

    a_jump_pc: assert property (accept && cmd_req.op == op_pointer_jump
        |=> pc_ff == $past(cmd_req.z_ptr) && !done ##1 done)
        else $error("pointer jump wrong");

    a_call_three: assert property (accept
        && cmd_req.op == op_pointer_subroutine_entry
        |=> rsp.push_ret && rsp.ret_addr == $past(pc_ff) + 16'h0001
        ##0 !done [*2] ##1 done)
        else $error("subroutine entry wrong");

    a_skip_two_word: assert property (accept && is_skip(cmd_req.op) && take
        && cmd_req.next_two_word |=> pc_ff == $past(pc_ff) + 16'h0003
        ##0 !done [*2] ##1 done)
        else $error("skip over two-word wrong");

    a_cpi_carry: assert property (accept
        && cmd_req.op == op_immediate_compare |=> status_ff[FLAG_C]
        == ($past(cmd_req.rd_val) < $past(cmd_req.imm)) && !rsp.wr_dest)
        else $error("compare carry wrong");

    a_signed_lt: assert property (accept
        && cmd_req.op == op_branch_signed_lt
        && (status_ff[FLAG_N] != status_ff[FLAG_V])
        |=> pc_ff == $past(pc_rel))
        else $error("signed less-than not taken");

    a_branch_flags: assert property (accept && (is_branch(cmd_req.op)
        || is_skip(cmd_req.op)) |=> status_ff == $past(status_ff))
        else $error("branch changed flags");

    c_branch_taken: cover property (accept && is_branch(cmd_req.op) && take);
    c_skip_taken: cover property (accept && is_skip(cmd_req.op) && take);
    c_back_to_back: cover property (accept ##1 accept);

endmodule // alu_exec

`default_nettype wire

/* pkg/alu_exec_pkg.sv */
`default_nettype none
package alu_exec_pkg;

    // ****************************************************************
    // Status register bit positions
    // ****************************************************************
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;

    // ****************************************************************
    // Register port map and reset values
    // ****************************************************************
    localparam logic [3:0] ADDR_STATUS = 4'h0;
    localparam logic [3:0] ADDR_PC = 4'h1;
    localparam logic [3:0] ADDR_RESULT = 4'h2;
    localparam logic [3:0] ADDR_STATE = 4'h3;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [15:0] PC_RESET = 16'h0000;

    // ****************************************************************
    // Cycle counts
    // ****************************************************************
    localparam logic [1:0] CYC_ONE = 2'h1;
    localparam logic [1:0] CYC_TWO = 2'h2;
    localparam logic [1:0] CYC_THREE = 2'h3;

    typedef enum logic [4:0] {
        op_or_immediate, op_set_bits_masked, op_clear_bits_masked,
        op_test_reg, op_unsigned_product, op_signed_product,
        op_mixed_sign_product, op_fractional_unsigned_product,
        op_fractional_signed_product, op_fractional_mixed_product,
        op_pointer_jump, op_pointer_subroutine_entry,
        op_equal_compare_skip, op_immediate_compare,
        op_skip_reg_bit_clear, op_skip_reg_bit_set,
        op_skip_port_bit_clear, op_skip_port_bit_set,
        op_branch_status_bit_set, op_branch_status_bit_clear,
        op_branch_carry_set, op_branch_carry_clear,
        op_branch_unsigned_ge, op_branch_unsigned_below,
        op_branch_signed_ge, op_branch_signed_lt,
        op_branch_half_carry_set, op_branch_half_carry_clear,
        op_branch_transfer_bit_set, op_branch_transfer_bit_clear,
        op_branch_overflow_set, op_branch_overflow_clear
    } exec_op_t;

    typedef struct packed {
        exec_op_t op;
        logic [7:0] rd_val;
        logic [7:0] rr_val;
        logic [7:0] imm;
        logic [2:0] bit_sel;
        logic [6:0] offset;
        logic [15:0] z_ptr;
        logic io_bit;
        logic next_two_word;
    } exec_req_t;

    typedef struct packed {
        logic wr_dest;
        logic [7:0] dest_val;
        logic wr_pair;
        logic [15:0] pair_val;
        logic push_ret;
        logic [15:0] ret_addr;
    } exec_rsp_t;

endpackage
`default_nettype wire

/* bench/tb_top.sv */
`default_nettype none
module tb_top
    import alu_exec_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] PCB = 16'h0100;
    logic clk_sys, reset_n, reg_wr, reg_rd, cmd_valid, cmd_ready, done;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata;
    exec_req_t cmd_req;
    exec_rsp_t rsp;
    int failures, total_checks;
    exec_op_t pop[7] = '{op_unsigned_product, op_signed_product,
        op_mixed_sign_product, op_fractional_unsigned_product,
        op_fractional_signed_product, op_fractional_mixed_product,
        op_unsigned_product};
    logic [7:0] pa[7] = '{8'hff, 8'hff, 8'hff, 8'h80, 8'h80, 8'h80, 8'h00};
    logic [7:0] pb[7] = '{8'hff, 8'hff, 8'h02, 8'h80, 8'h80, 8'h80, 8'h05};
    logic [15:0] pp[7] = '{16'hfe01, 16'h0001, 16'hfffe, 16'h8000,
        16'h8000, 16'h8000, 16'h0000};
    // Expected Z and C packed as bits 1 and 0
    logic [7:0] pf[7] = '{8'h01, 8'h00, 8'h01, 8'h00, 8'h00, 8'h01, 8'h02};
    exec_op_t bop[10] = '{op_branch_carry_set, op_branch_carry_clear,
        op_branch_unsigned_ge, op_branch_unsigned_below,
        op_branch_half_carry_set, op_branch_half_carry_clear,
        op_branch_transfer_bit_set, op_branch_transfer_bit_clear,
        op_branch_overflow_set, op_branch_overflow_clear};
    int bfl[10] = '{FLAG_C, FLAG_C, FLAG_C, FLAG_C, FLAG_H, FLAG_H,
        FLAG_T, FLAG_T, FLAG_V, FLAG_V};
    bit bpl[10] = '{1, 0, 0, 1, 1, 0, 1, 0, 1, 0};
    exec_op_t sk[4] = '{op_skip_reg_bit_clear, op_skip_reg_bit_set,
        op_skip_port_bit_clear, op_skip_port_bit_set};

    alu_exec uut (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .cmd_valid(cmd_valid), .cmd_req(cmd_req),
        .cmd_ready(cmd_ready), .done(done), .rsp(rsp));

    // ****************************************************************
    // Clock, verdict and watchdog
    // ****************************************************************
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic test_done;
        $display("Checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Whole run is about 870 cycles; leave ample margin
    initial begin
        repeat (6000) @(posedge clk_sys);
        failures++;
        $display("[FAIL] %0t watchdog expired", $time);
        test_done();
    end

    // ****************************************************************
    // Compare and access tasks
    // ****************************************************************
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_cyc(input logic [3:0] got, input logic [3:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t cycles %0d expected %0d", $time, got, exp);
        end
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk_val(reg_rdata, exp);
    endtask

    function automatic exec_req_t mk(input exec_op_t op,
        input logic [7:0] rd, input logic [7:0] rr, input logic [7:0] imm,
        input logic [2:0] b, input logic [6:0] off, input logic [15:0] z,
        input logic io, input logic two);
        mk = '{op, rd, rr, imm, b, off, z, io, two};
    endfunction

    // Offer one instruction, then count cycles from take to done
    task automatic run(input exec_req_t r, input logic [7:0] pre,
        input logic [3:0] n_exp, input logic [15:0] pc_exp,
        input logic [7:0] st_exp);
        int n;
        reg_write(ADDR_STATUS, {8'h00, pre});
        reg_write(ADDR_PC, PCB);
        @(posedge clk_sys);
        cmd_valid <= 1'b1;
        cmd_req <= r;
        @(posedge clk_sys);
        cmd_valid <= 1'b0;
        #1;
        chk_val({15'h0, cmd_ready}, {15'h0, n_exp == 4'd1});
        n = 1;
        while (done !== 1'b1 && n < 8) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        chk_cyc(n[3:0], n_exp);
        reg_read(ADDR_STATUS, {8'h00, st_exp});
        reg_read(ADDR_PC, pc_exp);
    endtask

    task automatic br(input exec_op_t op, input int f, input logic v,
        input logic tk);
        logic [7:0] m;
        m = 8'h01 << f;
        run(mk(op, 8'h55, 8'h55, 8'h00, 3'(f), 7'h7d, 16'hbeef, 1'b1, 1'b1),
            v ? m : ~m, tk ? 4'd2 : 4'd1, tk ? PCB - 16'h2 : PCB + 16'h1,
            v ? m : ~m);
    endtask

    // ****************************************************************
    // Test sequence
    // ****************************************************************
    initial begin
        logic [3:0] n;
        logic [1:0] nv;
        logic v, t, pt;
        {reg_wr, reg_rd, cmd_valid, reg_addr, reg_wdata} = '0;
        cmd_req = '0;
        failures = 0;
        total_checks = 0;
        reset_n = 1'b0;
        repeat (12) @(posedge clk_sys);
        reset_n <= 1'b1;
        reg_read(ADDR_STATUS, {8'h00, STATUS_RESET});
        reg_read(ADDR_PC, PC_RESET);
        reg_read(4'hf, 16'h0000);
        reg_read(ADDR_STATE, 16'h0000);
        run(mk(op_or_immediate, 8'h80, 8'h00, 8'h01, 3'h0, 7'h00, 16'h0,
            1'b0, 1'b0), 8'h09, 4'd1, PCB + 16'h1, 8'h05);
        chk_val({8'h00, rsp.dest_val}, 16'h0081);
        run(mk(op_set_bits_masked, 8'h00, 8'h00, 8'h00, 3'h0, 7'h00, 16'h0,
            1'b0, 1'b0), 8'h0c, 4'd1, PCB + 16'h1, 8'h02);
        run(mk(op_clear_bits_masked, 8'hff, 8'h00, 8'h0f, 3'h0, 7'h00,
            16'h0, 1'b0, 1'b0), 8'h09, 4'd1, PCB + 16'h1, 8'h05);
        chk_val({8'h00, rsp.dest_val}, 16'h00f0);
        run(mk(op_test_reg, 8'h00, 8'h00, 8'h00, 3'h0, 7'h00, 16'h0,
            1'b0, 1'b0), 8'h2d, 4'd1, PCB + 16'h1, 8'h23);
        for (int i = 0; i < 7; i++) begin
            run(mk(pop[i], pa[i], pb[i], 8'h00, 3'h0, 7'h00, 16'h0, 1'b0,
                1'b0), 8'hfc, 4'd2, PCB + 16'h1, 8'hfc | pf[i]);
            chk_val({15'h0, rsp.wr_pair}, 16'h0001);
            chk_val(rsp.pair_val, pp[i]);
            reg_read(ADDR_RESULT, pp[i]);
        end
        run(mk(op_pointer_jump, 8'h00, 8'h00, 8'h00, 3'h0, 7'h00, 16'h1234,
            1'b0, 1'b0), 8'h5a, 4'd2, 16'h1234, 8'h5a);
        run(mk(op_pointer_subroutine_entry, 8'h00, 8'h00, 8'h00, 3'h0, 7'h00,
            16'h0abc, 1'b0, 1'b0), 8'ha5, 4'd3, 16'h0abc, 8'ha5);
        chk_val({15'h0, rsp.push_ret}, 16'h0001);
        chk_val(rsp.ret_addr, PCB + 16'h1);
        for (int k = 0; k < 3; k++) begin
            run(mk(op_equal_compare_skip, 8'h33, (k == 0) ? 8'h34 : 8'h33,
                8'h00, 3'h0, 7'h00, 16'h0, 1'b0, k == 2), 8'h3c, 4'(k + 1),
                PCB + 16'(k + 1), 8'h3c);
        end
        run(mk(op_immediate_compare, 8'h10, 8'h00, 8'h01, 3'h0, 7'h00, 16'h0,
            1'b0, 1'b0), 8'h00, 4'd1, PCB + 16'h1, 8'h20);
        run(mk(op_immediate_compare, 8'h80, 8'h00, 8'h80, 3'h0, 7'h00, 16'h0,
            1'b0, 1'b0), 8'h40, 4'd1, PCB + 16'h1, 8'h42);
        run(mk(op_immediate_compare, 8'h05, 8'h00, 8'h10, 3'h0, 7'h00, 16'h0,
            1'b0, 1'b0), 8'h00, 4'd1, PCB + 16'h1, 8'h05);
        // Register skips get an opposite port bit, and the reverse
        for (int i = 0; i < 8; i++) begin
            {pt, v, t} = 3'(i);
            for (int s = 0; s < 2; s++) begin
                n = (v == s[0]) ? (t ? 4'd3 : 4'd2) : 4'd1;
                run(mk(sk[{pt, s[0]}], 8'h00, (v ^ pt) ? 8'h08 : 8'hf7, 8'h00,
                    3'h3, 7'h00, 16'h0, v ^ !pt, t), 8'hc3, n,
                    PCB + {12'h0, n}, 8'hc3);
            end
        end
        for (int i = 0; i < 10; i++) begin
            for (int s = 0; s < 2; s++) begin
                br(bop[i], bfl[i], s[0], s[0] == bpl[i]);
            end
        end
        for (int b = 0; b < 16; b++) begin
            br(b[3] ? op_branch_status_bit_set : op_branch_status_bit_clear,
                b % 8, b[0], b[0] == b[3]);
        end
        for (int s = 0; s < 4; s++) begin
            nv = 2'(s);
            run(mk(op_branch_signed_ge, 8'h00, 8'h00, 8'h00, 3'h0, 7'h7d,
                16'h0, 1'b0, 1'b0), {4'h0, nv, 2'b00},
                (nv[0] == nv[1]) ? 4'd2 : 4'd1,
                (nv[0] == nv[1]) ? PCB - 16'h2 : PCB + 16'h1,
                {4'h0, nv, 2'b00});
            run(mk(op_branch_signed_lt, 8'h00, 8'h00, 8'h00, 3'h0, 7'h7d,
                16'h0, 1'b0, 1'b0), {4'h0, nv, 2'b00},
                (nv[0] != nv[1]) ? 4'd2 : 4'd1,
                (nv[0] != nv[1]) ? PCB - 16'h2 : PCB + 16'h1,
                {4'h0, nv, 2'b00});
        end
        test_done();
    end
endmodule // tb_top
`default_nettype wire
